// >>> design/debug_patch_and_flash_power.v
`timescale 1ns/100ps
`include "dbg_patch_defines.vh"

// Functional notes
// - Opcode a5 acts as a breakpoint and sets the flash/debug interrupt flag.
// - After a breakpoint the core stalls until the interrupt is taken or three cycles pass.
// - On return with the flag still set, exactly one instruction runs first.
// - The flash/debug interrupt vectors to 0x33; handler clears flag and returns.
// - A fetch at the patch address returns the patch data byte instead.
// - A zero patch address disables substitution entirely.
// - Patch address is two read/write bytes at bb (high) and ba (low).
// - Patch data byte is read/write at b9 with zero reset.
// - Any fetched byte may be replaced, opcode or operand alike.
// - Scratch byte at e7 is read/write and affects nothing.
// - Version register at 9f is read only: type in 7:2, revision in 1:0.
// - After reset the flash is kept always active.
// - The flash may sleep between fetches and during idle or stop.
// - Low-power field: 00 active, 01 idle standby, 10 fetch standby, 11 reserved.
module debug_patch_and_flash_power #(
  parameter       AW        = 12,
  parameter [5:0] CHIP_TYPE = 6'h2a, // Arbitrary value.
  parameter [1:0] REV_CODE  = 2'h2   // Arbitrary value.
) (
  // Clock and reset.
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite register bus.
  input  wire [AW-1:0] s_awaddr,
  input  wire          s_awvalid,
  output wire          s_awready,
  input  wire [31:0]   s_wdata,
  input  wire [3:0]    s_wstrb,
  input  wire          s_wvalid,
  output wire          s_wready,
  output wire [1:0]    s_bresp,
  output wire          s_bvalid,
  input  wire          s_bready,
  input  wire [AW-1:0] s_araddr,
  input  wire          s_arvalid,
  output wire          s_arready,
  output wire [31:0]   s_rdata,
  output wire [1:0]    s_rresp,
  output wire          s_rvalid,
  input  wire          s_rready,
  // Core special-register port.
  input  wire [7:0]    sfr_addr,
  input  wire          sfr_wr,
  input  wire [7:0]    sfr_wdata,
  output wire [7:0]    sfr_rdata,
  output wire          sfr_hit,
  // Core fetch path.
  input  wire [15:0]   fetch_addr,
  input  wire          fetch_valid,
  input  wire          fetch_is_opcode,
  input  wire [7:0]    flash_rdata,
  output wire [7:0]    fetch_rdata,
  // Core interrupt control.
  input  wire          irq_flag_clear,
  input  wire          irq_taken,
  input  wire          reti_done,
  input  wire          insn_done,
  output wire          flash_debug_irq_flag,
  output wire          core_stall,
  output wire          irq_block,
  output wire [15:0]   debug_vector,
  // Flash power and core mode.
  input  wire          core_idle,
  output reg           flash_standby,
  // Interrupt to the system.
  output wire          irq
);

  // Trap sequence states.
  localparam [2:0] ST_RUN   = 3'b001;
  localparam [2:0] ST_STALL = 3'b010;
  localparam [2:0] ST_STEP  = 3'b100;

  reg  [7:0]  patch_data_q;
  reg  [7:0]  patch_lo_q;
  reg  [7:0]  patch_hi_q;
  reg  [7:0]  scratch_q;
  reg  [1:0]  lp_sel_q;
  reg         fd_flag_q;
  reg  [2:0]  state_q;
  reg  [2:0]  stall_cnt_q;
  reg  [`IRQ_BITS-1:0] irq_stat_q;
  reg  [`IRQ_BITS-1:0] irq_en_q;
  reg  [7:0]  axi_rd_mux;
  reg         axi_rd_ok;
  reg         axi_wr_ok;
  reg  [7:0]  sfr_rd_mux;
  reg         sfr_hit_c;
  wire        wr_en;
  wire [AW-1:0] wr_addr;
  wire [7:0]  wr_data;
  wire        rd_en;
  wire [AW-1:0] rd_addr;
  wire        patch_hit;
  wire        trap_exec;
  wire [15:0] patch_address;
  wire [`IRQ_BITS-1:0] irq_events;

  // Maps a bus byte address onto the special-register offset it mirrors.
  function [7:0] axi_to_sfr;
    input [AW-1:0] a;
    begin
      case (a)
        `AXI_CHIP_VERSION:     axi_to_sfr = `SFR_CHIP_VERSION;
        `AXI_PATCH_DATA:       axi_to_sfr = `SFR_PATCH_DATA;
        `AXI_PATCH_ADDR_LOW:   axi_to_sfr = `SFR_PATCH_ADDR_LOW;
        `AXI_PATCH_ADDR_HIGH:  axi_to_sfr = `SFR_PATCH_ADDR_HIGH;
        `AXI_DEBUGGER_SCRATCH: axi_to_sfr = `SFR_DEBUGGER_SCRATCH;
        default:               axi_to_sfr = 8'h00;
      endcase
    end
  endfunction

  // Reads a mirrored special register by its offset.
  function [8:0] sfr_read;
    input [7:0] a;
    input [7:0] pd;
    input [7:0] pl;
    input [7:0] ph;
    input [7:0] sc;
    begin
      case (a)
        `SFR_CHIP_VERSION:     sfr_read = {1'b1, CHIP_TYPE, REV_CODE};
        `SFR_PATCH_DATA:       sfr_read = {1'b1, pd};
        `SFR_PATCH_ADDR_LOW:   sfr_read = {1'b1, pl};
        `SFR_PATCH_ADDR_HIGH:  sfr_read = {1'b1, ph};
        `SFR_DEBUGGER_SCRATCH: sfr_read = {1'b1, sc};
        default:               sfr_read = 9'h000;
      endcase
    end
  endfunction

  // Bus slave.
  axil_regs_if #(
    .AW (AW)
  ) u_bus (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_ok     (axi_wr_ok),
    .rd_en     (rd_en),
    .rd_addr   (rd_addr),
    .rd_data   (axi_rd_mux),
    .rd_ok     (axi_rd_ok)
  );

  // Replacement address is the concatenation of the two bytes.
  assign patch_address = {patch_hi_q, patch_lo_q};

  // Same-cycle substitution on the fetch bus.
  fetch_patch u_patch (
    .fetch_addr    (fetch_addr),
    .fetch_valid   (fetch_valid),
    .flash_rdata   (flash_rdata),
    .fetch_rdata   (fetch_rdata),
    .patch_address (patch_address),
    .patch_data    (patch_data_q),
    .patch_hit     (patch_hit)
  );

  // A trap is an opcode fetch that delivers a5, whether from flash or the patch.
  assign trap_exec = fetch_valid && fetch_is_opcode && (fetch_rdata == `TRAP_OPCODE);

  // Bus write decode: writable offsets, the version offset (write ignored) and control registers.
  always @* begin
    case (wr_addr)
      `AXI_PATCH_DATA, `AXI_PATCH_ADDR_LOW, `AXI_PATCH_ADDR_HIGH, `AXI_DEBUGGER_SCRATCH,
      `AXI_CHIP_VERSION, `AXI_POWER_CTRL, `AXI_IRQ_ENABLE, `AXI_IRQ_CLEAR:
        axi_wr_ok = 1'b1;
      default:
        axi_wr_ok = 1'b0;
    endcase
  end

  // Bus read decode.
  always @* begin
    case (rd_addr)
      `AXI_POWER_CTRL: begin
        axi_rd_mux = {6'h00, lp_sel_q};
        axi_rd_ok  = 1'b1;
      end
      `AXI_IRQ_STATUS: begin
        axi_rd_mux = {{(8-`IRQ_BITS){1'b0}}, irq_stat_q};
        axi_rd_ok  = 1'b1;
      end
      `AXI_IRQ_ENABLE: begin
        axi_rd_mux = {{(8-`IRQ_BITS){1'b0}}, irq_en_q};
        axi_rd_ok  = 1'b1;
      end
      `AXI_IRQ_CLEAR: begin
        axi_rd_mux = 8'h00;
        axi_rd_ok  = 1'b1;
      end
      `AXI_CORE_STATUS: begin
        axi_rd_mux = {5'h00, state_q == ST_STEP, state_q == ST_STALL, fd_flag_q};
        axi_rd_ok  = 1'b1;
      end
      default: begin
        {axi_rd_ok, axi_rd_mux} = sfr_read(axi_to_sfr(rd_addr), patch_data_q, patch_lo_q, patch_hi_q, scratch_q);
      end
    endcase
  end

  // Core-side special-register reads.
  always @* begin
    {sfr_hit_c, sfr_rd_mux} = sfr_read(sfr_addr, patch_data_q, patch_lo_q, patch_hi_q, scratch_q);
  end
  assign sfr_rdata = sfr_rd_mux;
  assign sfr_hit   = sfr_hit_c;

  // Register file; the core port wins a same-cycle collision with the bus.
  always @(posedge aclk) begin
    if (!aresetn) begin
      patch_data_q <= `PATCH_RESET;
      patch_lo_q   <= `PATCH_RESET;
      patch_hi_q   <= `PATCH_RESET;
      scratch_q    <= `SCRATCH_RESET;
      lp_sel_q     <= `PWR_LP_RESET;
      irq_en_q     <= {`IRQ_BITS{1'b0}};
    end else begin
      if (wr_en) begin
        case (wr_addr)
          `AXI_PATCH_DATA:       patch_data_q <= wr_data;
          `AXI_PATCH_ADDR_LOW:   patch_lo_q   <= wr_data;
          `AXI_PATCH_ADDR_HIGH:  patch_hi_q   <= wr_data;
          `AXI_DEBUGGER_SCRATCH: scratch_q    <= wr_data;
          `AXI_POWER_CTRL:       lp_sel_q     <= wr_data[`PWR_LP_MSB:`PWR_LP_LSB];
          `AXI_IRQ_ENABLE:       irq_en_q     <= wr_data[`IRQ_BITS-1:0];
          default:               ;
        endcase
      end
      if (sfr_wr) begin
        case (sfr_addr)
          `SFR_PATCH_DATA:       patch_data_q <= sfr_wdata;
          `SFR_PATCH_ADDR_LOW:   patch_lo_q   <= sfr_wdata;
          `SFR_PATCH_ADDR_HIGH:  patch_hi_q   <= sfr_wdata;
          `SFR_DEBUGGER_SCRATCH: scratch_q    <= sfr_wdata;
          default:               ;
        endcase
      end
    end
  end

  // Flash/debug flag: set by a trap, cleared by the handler; setting wins.
  always @(posedge aclk) begin
    if (!aresetn) begin
      fd_flag_q <= 1'b0;
    end else if (trap_exec) begin
      fd_flag_q <= 1'b1;
    end else if (irq_flag_clear) begin
      fd_flag_q <= 1'b0;
    end
  end
  assign flash_debug_irq_flag = fd_flag_q;
  assign debug_vector         = `DEBUG_VECTOR;

  // Trap stall and single-step sequencing.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= ST_RUN;
      stall_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (trap_exec) begin
            state_q     <= ST_STALL;
            stall_cnt_q <= `TRAP_STALL_CYCLES;
          end else if (reti_done && fd_flag_q) begin
            state_q <= ST_STEP;
          end
        end
        ST_STALL: begin
          if (irq_taken || stall_cnt_q == 3'h0) begin
            state_q <= ST_RUN;
          end else begin
            stall_cnt_q <= stall_cnt_q - 3'h1;
          end
        end
        ST_STEP: begin
          if (insn_done) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Stall holds the core until the interrupt is taken or the stall count runs out; block lets one step run.
  assign core_stall = (state_q == ST_STALL) && !irq_taken;
  assign irq_block  = (state_q == ST_STEP) || (state_q == ST_RUN && reti_done);

  // Flash standby per the low-power field; reserved code keeps it active.
  always @(posedge aclk) begin
    if (!aresetn) begin
      flash_standby <= 1'b0;
    end else begin
      case (lp_sel_q)
        `LP_STANDBY_IDLE:  flash_standby <= core_idle;
        `LP_STANDBY_FETCH: flash_standby <= core_idle || !fetch_valid;
        default:           flash_standby <= 1'b0;
      endcase
    end
  end

  // Sticky event bits, enable mask and write-one-to-clear; set wins.
  assign irq_events = {reti_done && fd_flag_q, patch_hit, trap_exec};
  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_BITS; gi = gi + 1) begin : g_irq
      always @(posedge aclk) begin
        if (!aresetn) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_events[gi]) begin
          irq_stat_q[gi] <= 1'b1;
        end else if (wr_en && wr_addr == `AXI_IRQ_CLEAR && wr_data[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  assign irq = |(irq_stat_q & irq_en_q);

endmodule

// >>> design/dbg_patch_defines.vh
`ifndef DBG_PATCH_DEFINES_VH
`define DBG_PATCH_DEFINES_VH

// Special-register offsets seen from the core side.
`define SFR_CHIP_VERSION      8'h9f
`define SFR_PATCH_DATA        8'hb9
`define SFR_PATCH_ADDR_LOW    8'hba
`define SFR_PATCH_ADDR_HIGH   8'hbb
`define SFR_DEBUGGER_SCRATCH  8'he7

// AXI4-Lite byte addresses (the core offsets are not word aligned, so index times four).
`define AXI_CHIP_VERSION      12'h27c
`define AXI_PATCH_DATA        12'h2e4
`define AXI_PATCH_ADDR_LOW    12'h2e8
`define AXI_PATCH_ADDR_HIGH   12'h2ec
`define AXI_DEBUGGER_SCRATCH  12'h39c
`define AXI_POWER_CTRL        12'h400
`define AXI_IRQ_STATUS        12'h404
`define AXI_IRQ_ENABLE        12'h408
`define AXI_IRQ_CLEAR         12'h40c
`define AXI_CORE_STATUS       12'h410

// Field positions and reset values.
`define PWR_LP_LSB            0
`define PWR_LP_MSB            1
`define PWR_LP_RESET          2'h0
`define LP_ALWAYS_ACTIVE      2'h0
`define LP_STANDBY_IDLE       2'h1
`define LP_STANDBY_FETCH      2'h2
`define PATCH_RESET           8'h00
`define SCRATCH_RESET         8'h00
`define IRQ_BIT_TRAP          0
`define IRQ_BIT_PATCH_HIT     1
`define IRQ_BIT_STEP          2
`define IRQ_BITS              3

// Core-side constants.
`define TRAP_OPCODE           8'ha5
`define DEBUG_VECTOR          16'h0033
`define TRAP_STALL_CYCLES     3'h2

// AXI responses.
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// >>> design/axil_regs_if.v
`timescale 1ns/100ps
`include "dbg_patch_defines.vh"

// AXI4-Lite slave front end; presents one-cycle write and read strobes.
module axil_regs_if #(
  parameter AW = 12
) (
  // Clock and reset.
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite.
  input  wire [AW-1:0] s_awaddr,
  input  wire          s_awvalid,
  output wire          s_awready,
  input  wire [31:0]   s_wdata,
  input  wire [3:0]    s_wstrb,
  input  wire          s_wvalid,
  output wire          s_wready,
  output reg  [1:0]    s_bresp,
  output reg           s_bvalid,
  input  wire          s_bready,
  input  wire [AW-1:0] s_araddr,
  input  wire          s_arvalid,
  output wire          s_arready,
  output reg  [31:0]   s_rdata,
  output reg  [1:0]    s_rresp,
  output reg           s_rvalid,
  input  wire          s_rready,
  // Register side.
  output wire          wr_en,
  output wire [AW-1:0] wr_addr,
  output wire [7:0]    wr_data,
  input  wire          wr_ok,
  output wire          rd_en,
  output wire [AW-1:0] rd_addr,
  input  wire [7:0]    rd_data,
  input  wire          rd_ok
);

  reg [AW-1:0] aw_q;
  reg          aw_have_q;
  reg [7:0]    w_q;
  reg          w_stb_q;
  reg          w_have_q;

  // Address and data are caught independently; each is refused while held.
  assign s_awready = !aw_have_q && !s_bvalid;
  assign s_wready  = !w_have_q && !s_bvalid;
  assign wr_en     = aw_have_q && w_have_q && !s_bvalid;
  assign wr_addr   = aw_q;
  assign wr_data   = w_stb_q ? w_q : 8'h00;
  assign s_arready = !s_rvalid;
  assign rd_en     = s_arvalid && !s_rvalid;
  assign rd_addr   = s_araddr;

  // Write channel capture and response.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q      <= {AW{1'b0}};
      aw_have_q <= 1'b0;
      w_q       <= 8'h00;
      w_stb_q   <= 1'b0;
      w_have_q  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_q      <= s_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        w_q      <= s_wdata[7:0];
        w_stb_q  <= s_wstrb[0];
        w_have_q <= 1'b1;
      end
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data registered on the same edge that takes the address.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= `RESP_OKAY;
    end else if (rd_en) begin
      s_rvalid <= 1'b1;
      s_rdata  <= {24'h00_0000, rd_data};
      s_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule

// >>> design/fetch_patch.v
`timescale 1ns/100ps
`include "dbg_patch_defines.vh"

// Fetch-path byte replacement and patch hit detection, purely combinational.
module fetch_patch (
  // Fetch bus.
  input  wire [15:0] fetch_addr,
  input  wire        fetch_valid,
  input  wire [7:0]  flash_rdata,
  output wire [7:0]  fetch_rdata,
  // Patch settings.
  input  wire [15:0] patch_address,
  input  wire [7:0]  patch_data,
  // Status.
  output wire        patch_hit
);

  // Substitution is armed only for a nonzero address and works on any byte.
  assign patch_hit   = fetch_valid && (patch_address != 16'h0000) && (fetch_addr == patch_address);
  assign fetch_rdata = patch_hit ? patch_data : flash_rdata;

endmodule

// >>> verif/dbg_patch_checker_properties.sv
`timescale 1ns/100ps

// Watches the fetch, trap, stepping and flash power ports of the debug block.
module dbg_patch_checker (
  // Clock and reset.
  input wire        aclk,
  input wire        aresetn,
  // Fetch path.
  input wire [15:0] fetch_addr,
  input wire        fetch_valid,
  input wire        fetch_is_opcode,
  input wire [7:0]  flash_rdata,
  input wire [7:0]  fetch_rdata,
  // Core interrupt control.
  input wire        irq_flag_clear,
  input wire        reti_done,
  input wire        insn_done,
  input wire        flash_debug_irq_flag,
  input wire        core_stall,
  input wire        irq_block,
  input wire [15:0] debug_vector,
  // Flash power.
  input wire        core_idle,
  input wire        flash_standby
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A fetched opcode that carries the breakpoint value.
  wire trap_fetch = fetch_valid && fetch_is_opcode && (fetch_rdata == 8'ha5);

  zero_pass_a: assert property (fetch_valid && fetch_addr == 16'h0000 |-> fetch_rdata == flash_rdata)
    else $error("Fetch at address zero was replaced.");
  trap_flag_a: assert property (trap_fetch |=> flash_debug_irq_flag)
    else $error("Breakpoint opcode did not set the flag.");
  trap_stall_a: assert property (trap_fetch |=> core_stall)
    else $error("Breakpoint opcode did not stall the core.");
  stall_bound_a: assert property ($rose(core_stall) |-> ##[1:4] !core_stall)
    else $error("Core stall lasted too long.");
  flag_clear_a: assert property (irq_flag_clear && !trap_fetch |=> !flash_debug_irq_flag)
    else $error("Handler clear left the flag set.");
  debug_vec_a: assert property (debug_vector == 16'h0033)
    else $error("Debug vector is wrong.");
  step_block_a: assert property (reti_done && flash_debug_irq_flag |-> irq_block)
    else $error("Return with flag set did not block.");
  step_release_a: assert property (irq_block && insn_done && !reti_done |=> !irq_block || reti_done)
    else $error("Block held after one instruction.");
  reset_active_a: assert property ($rose(aresetn) |-> !flash_standby)
    else $error("Flash not active after reset.");
  busy_awake_a: assert property (fetch_valid && !core_idle |=> !flash_standby)
    else $error("Flash in standby during a fetch.");
endmodule

bind debug_patch_and_flash_power dbg_patch_checker chk (
  .aclk                 (aclk),
  .aresetn              (aresetn),
  .fetch_addr           (fetch_addr),
  .fetch_valid          (fetch_valid),
  .fetch_is_opcode      (fetch_is_opcode),
  .flash_rdata          (flash_rdata),
  .fetch_rdata          (fetch_rdata),
  .irq_flag_clear       (irq_flag_clear),
  .reti_done            (reti_done),
  .insn_done            (insn_done),
  .flash_debug_irq_flag (flash_debug_irq_flag),
  .core_stall           (core_stall),
  .irq_block            (irq_block),
  .debug_vector         (debug_vector),
  .core_idle            (core_idle),
  .flash_standby        (flash_standby)
);

// >>> verif/flash_model.sv
`timescale 1ns/100ps

// Program flash seen by the fetch path; data is a fixed function of the address.
module flash_model (
  // Clock.
  input  wire        aclk,
  // Fetch bus.
  input  wire [15:0] fetch_addr,
  input  wire        fetch_valid,
  output wire [7:0]  flash_rdata
);
  reg  [7:0] last_q;
  wire [7:0] word = fetch_addr[7:0] ^ fetch_addr[15:8] ^ 8'h5c;

  initial last_q = 8'h00;

  // Remember the last byte so an idle bus shows its inverse, never a stale match.
  always @(posedge aclk) if (fetch_valid) last_q <= word;
  assign flash_rdata = fetch_valid ? word : ~last_q;
endmodule

// >>> verif/debug_patch_and_flash_power_tb.sv
`timescale 1ns/100ps

// Compares a value and counts the outcome.
`define CHECK(g, e) begin tests_run = tests_run + 1; if ((g) !== (e)) begin bad_count = bad_count + 1; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module debug_patch_and_flash_power_tb;
  reg         aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, sfr_wr;
  reg  [11:0] s_awaddr, s_araddr;
  reg  [31:0] s_wdata;
  reg  [3:0]  s_wstrb;
  reg  [7:0]  sfr_addr, sfr_wdata;
  reg  [15:0] fetch_addr;
  reg         fetch_valid, fetch_is_opcode, irq_flag_clear, irq_taken, reti_done, insn_done, core_idle;
  wire        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, sfr_hit, flash_debug_irq_flag;
  wire        core_stall, irq_block, flash_standby, irq;
  wire [1:0]  s_bresp, s_rresp;
  wire [31:0] s_rdata;
  wire [7:0]  sfr_rdata, flash_rdata, fetch_rdata;
  wire [15:0] debug_vector;
  integer     bad_count, tests_run, i, n;
  reg  [37:0] rows [0:8];
  reg  [15:0] fa [0:4];

  debug_patch_and_flash_power uut (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_is_opcode(fetch_is_opcode),
    .flash_rdata(flash_rdata), .fetch_rdata(fetch_rdata), .irq_flag_clear(irq_flag_clear),
    .irq_taken(irq_taken), .reti_done(reti_done), .insn_done(insn_done),
    .flash_debug_irq_flag(flash_debug_irq_flag), .core_stall(core_stall), .irq_block(irq_block),
    .debug_vector(debug_vector), .core_idle(core_idle), .flash_standby(flash_standby), .irq(irq));

  flash_model fm (.aclk(aclk), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .flash_rdata(flash_rdata));

  // Expected flash byte for an address.
  function [7:0] pat(input [15:0] a);
    pat = a[7:0] ^ a[15:8] ^ 8'h5c;
  endfunction

  // Prints the counts and the verdict, then stops.
  task end_sim;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  // A wait that ran out counts as a mismatch.
  task hang;
    begin
      bad_count = bad_count + 1;
      end_sim;
    end
  endtask

  // One AXI4-Lite write; address and data are offered together and released when taken.
  task axi_wr(input [11:0] a, input [7:0] d, input [1:0] er);
    reg aw_ok, w_ok, aw_t, w_t;
    begin
      s_awaddr  <= a;
      s_wdata   <= {24'h0, d};
      s_wstrb   <= 4'h1;
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      aw_ok = 0;
      w_ok = 0;
      for (n = 0; !(aw_ok && w_ok); n = n + 1) begin
        if (n == 40) hang;
        #1;
        aw_t = s_awready && !aw_ok;
        w_t = s_wready && !w_ok;
        @(posedge aclk);
        if (aw_t) s_awvalid <= 1'b0;
        if (w_t) s_wvalid <= 1'b0;
        aw_ok = aw_ok || aw_t;
        w_ok = w_ok || w_t;
      end
      #1;
      for (n = 0; !s_bvalid; n = n + 1) begin
        if (n == 40) hang;
        @(posedge aclk);
        #1;
      end
      `CHECK(s_bresp, er)
      @(posedge aclk);
      s_bready <= 1'b0;
    end
  endtask

  // One AXI4-Lite read; the answer is compared with the expected byte and response.
  task rd_chk(input [11:0] a, input [7:0] ed, input [1:0] er);
    begin
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      #1;
      for (n = 0; !s_arready; n = n + 1) begin
        if (n == 40) hang;
        @(posedge aclk);
        #1;
      end
      @(posedge aclk);
      s_arvalid <= 1'b0;
      #1;
      for (n = 0; !s_rvalid; n = n + 1) begin
        if (n == 40) hang;
        @(posedge aclk);
        #1;
      end
      `CHECK(s_rdata, {24'h0, ed})
      `CHECK(s_rresp, er)
      @(posedge aclk);
      s_rready <= 1'b0;
    end
  endtask

  // Presents one fetch, left on the bus until changed, and lets the combinational answer settle.
  task fetch(input [15:0] a, input op);
    begin
      @(posedge aclk);
      fetch_addr      <= a;
      fetch_valid     <= 1'b1;
      fetch_is_opcode <= op;
      #1;
    end
  endtask

  // Pulses one core control line for a cycle.
  task pulse(input integer which);
    begin
      @(posedge aclk);
      irq_taken      <= (which == 0);
      reti_done      <= (which == 1);
      insn_done      <= (which == 2);
      irq_flag_clear <= (which == 3);
      fetch_valid    <= 1'b0;
      #1;
    end
  endtask

  // Free-running core clock.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, sfr_wr} = 6'h00;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = 60'h0;
    {sfr_addr, sfr_wdata, fetch_addr} = 32'h0;
    {fetch_valid, fetch_is_opcode, irq_flag_clear, irq_taken, reti_done, insn_done, core_idle} = 7'h00;
    bad_count = 0;
    tests_run = 0;
    aresetn = 1'b0;
    // Rows: address, reset value, written byte, byte read back, response.
    rows[0] = {12'h27c, 8'haa, 8'hff, 8'haa, 2'h0};
    rows[1] = {12'h2e4, 8'h00, 8'h3c, 8'h3c, 2'h0};
    rows[2] = {12'h2e8, 8'h00, 8'h34, 8'h34, 2'h0};
    rows[3] = {12'h2ec, 8'h00, 8'h12, 8'h12, 2'h0};
    rows[4] = {12'h39c, 8'h00, 8'h5a, 8'h5a, 2'h0};
    rows[5] = {12'h400, 8'h00, 8'h01, 8'h01, 2'h0};
    rows[6] = {12'h408, 8'h00, 8'h07, 8'h07, 2'h0};
    rows[7] = {12'h40c, 8'h00, 8'h00, 8'h00, 2'h0};
    rows[8] = {12'h100, 8'h00, 8'h11, 8'h00, 2'h2};
    fa[0] = 16'h1234;
    fa[1] = 16'h1235;
    fa[2] = 16'h0034;
    fa[3] = 16'h1334;
    fa[4] = 16'h0000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHECK(debug_vector, 16'h0033)
    for (i = 0; i < 9; i = i + 1) begin
      rd_chk(rows[i][37:26], rows[i][25:18], rows[i][1:0]);
      axi_wr(rows[i][37:26], rows[i][17:10], rows[i][1:0]);
      rd_chk(rows[i][37:26], rows[i][9:2], rows[i][1:0]);
    end
    // Patch 0x1234 with 0x3c; operand fetches there are replaced in the same cycle.
    for (i = 0; i < 5; i = i + 1) begin
      fetch(fa[i], i[0]);
      `CHECK(fetch_rdata, (fa[i] == 16'h1234) ? 8'h3c : pat(fa[i]))
    end
    fetch(16'h1234, 1'b0);
    `CHECK(fetch_rdata, 8'h3c)
    `CHECK(irq, 1'b1)
    pulse(4);
    rd_chk(12'h404, 8'h02, 2'h0);
    axi_wr(12'h408, 8'h00, 2'h0);
    `CHECK(irq, 1'b0)
    axi_wr(12'h40c, 8'h07, 2'h0);
    rd_chk(12'h404, 8'h00, 2'h0);
    // Scratch written by the core is stored and disturbs nothing else.
    @(posedge aclk);
    sfr_addr  <= 8'he7;
    sfr_wdata <= 8'h77;
    sfr_wr    <= 1'b1;
    @(posedge aclk);
    sfr_wr <= 1'b0;
    #1;
    `CHECK({sfr_hit, sfr_rdata}, 9'h177)
    fetch(16'h1234, 1'b1);
    `CHECK(fetch_rdata, 8'h3c)
    @(posedge aclk);
    sfr_addr <= 8'h9f;
    #1;
    `CHECK(sfr_rdata, 8'haa)
    // Move the patch to 0x0040 as a soft breakpoint, high byte first.
    axi_wr(12'h2ec, 8'h00, 2'h0);
    axi_wr(12'h2e8, 8'h40, 2'h0);
    axi_wr(12'h2e4, 8'ha5, 2'h0);
    axi_wr(12'h408, 8'h01, 2'h0);
    fetch(16'h0040, 1'b1);
    `CHECK(fetch_rdata, 8'ha5)
    @(posedge aclk);
    fetch_valid <= 1'b0;
    #1;
    `CHECK({flash_debug_irq_flag, core_stall, irq}, 3'h7)
    for (n = 0; core_stall && n < 8; n = n + 1) @(posedge aclk) #1;
    `CHECK(n, 3)
    pulse(0);
    pulse(1);
    `CHECK(irq_block, 1'b1)
    pulse(4);
    `CHECK(irq_block, 1'b1)
    pulse(2);
    pulse(4);
    `CHECK(irq_block, 1'b0)
    rd_chk(12'h404, 8'h07, 2'h0);
    pulse(3);
    pulse(4);
    `CHECK(flash_debug_irq_flag, 1'b0)
    // Every low-power code, idle core, then busy core with the bus quiet.
    for (i = 0; i < 4; i = i + 1) begin
      axi_wr(12'h400, i[7:0], 2'h0);
      core_idle <= 1'b1;
      repeat (2) @(posedge aclk);
      #1;
      `CHECK(flash_standby, (i == 1 || i == 2))
      core_idle <= 1'b0;
      repeat (2) @(posedge aclk);
      #1;
      `CHECK(flash_standby, (i == 2))
    end
    // A second reset brings the flash back to always active.
    axi_wr(12'h400, 8'h02, 2'h0);
    core_idle <= 1'b1;
    aresetn   <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    `CHECK(flash_standby, 1'b0)
    rd_chk(12'h400, 8'h00, 2'h0);
    fetch(16'h0000, 1'b0);
    `CHECK(fetch_rdata, 8'h5c)
    end_sim;
  end
endmodule
